/* pwm_engine_pkg.sv */
package pwm_engine_pkg;

  localparam int CountWidth = 12;
  localparam int DividerWidth = 8;
  localparam int DelayWidth = 8;

  // Reset values of the counter, of the prescale divider and of the filter taps.
  localparam logic [11:0] CountReset = 12'h0000;
  localparam logic [7:0] DividerReset = 8'h00;
  localparam logic [3:0] FilterReset = 4'h0;

  // Digital filter length in counter clocks.
  localparam int FilterTaps = 4;

  // Value of the delay function select field that turns on input blanking.
  localparam logic [1:0] DelayBlanking = 2'h1;

  typedef enum logic [1:0] {
    SCHEME_ONE_RAMP = 2'b00,
    SCHEME_TWO_RAMP = 2'b01,
    SCHEME_FOUR_RAMP = 2'b10,
    SCHEME_DUAL_SLOPE = 2'b11
  } scheme_type;

  typedef enum logic [1:0] {
    DEAD_TIME_FIRST = 2'b00,
    ON_TIME_FIRST = 2'b01,
    DEAD_TIME_SECOND = 2'b10,
    ON_TIME_SECOND = 2'b11
  } cycle_state_type;

  typedef enum logic [3:0] {
    FAULT_NONE = 4'h0,
    FAULT_JUMP_WAIT = 4'h1,
    FAULT_EXEC_WAIT = 4'h2,
    FAULT_EXEC_ACTIVE = 4'h3,
    FAULT_STOP_ALL = 4'h4,
    FAULT_DEAD_ACTIVE = 4'h5,
    FAULT_ALL_JUMP_WAIT = 4'h6,
    FAULT_SOFTWARE = 4'h7,
    FAULT_EDGE_JUMP = 4'h8,
    FAULT_EDGE_STOP = 4'h9,
    FAULT_LEVEL_STOP = 4'hA
  } fault_behaviour_type;

  typedef struct packed {
    logic [11:0] setFirst;
    logic [11:0] clearFirst;
    logic [11:0] setSecond;
    logic [11:0] clearSecond;
  } compare_set_type;

  typedef struct packed {
    logic triggerInputEnable;
    logic captureAction;
    logic filterEnable;
    logic unsynchronizedDetectEnable;
    logic [3:0] faultBehaviourSelect;
  } input_control_type;

  typedef struct packed {
    logic [1:0] delayFunctionSelect;
    logic [1:0] delayTriggerSource;
    logic [1:0] delayClockDivider;
    logic [7:0] delayCountValue;
  } delay_control_type;

endpackage : pwm_engine_pkg

/* dead_time_pwm_cycle_engine.sv */
// Summary of operation
// R01: Counter clock is sync prescale times counter prescale.
// R02: Cycle runs dead, on, dead, on states.
// R03: Four counting schemes picked by scheme select.
// R04: One ramp counts zero to clear-second, restarts.
// R05: Compares above clear-second or clear below set ignored.
// R06: Software orders compares to avoid overlap.
// R07: Two ramp counts to clear-first, then clear-second.
// R08: Four ramp runs four ramps ending at compares.
// R09: Dual slope counts down to zero, back up.
// R10: Dual slope first output set up, cleared down.
// R11: Dual slope second output set down, cleared up.
// R12: Dual slope ignores clear-first compare entirely.
// R13: Dual slope starts down; first output waits cycle.
// R14: Inputs act only when trigger enabled; capture optional.
// R15: Ten fault behaviours; blanking on first input only.
// R16: Synchronous override two to three clocks late.
// R17: Blanking when delay select one; trigger picks point.
// R18: Delay counter ends blanking after programmed count.
// R19: Software never mixes blanking with delayed event.
// R20: Filter rejects pulses under four counter clocks.
// R21: Unsynchronized detect overrides outputs, flow waits synchronizer.
// R22: Software never mixes unsynchronized detect and filter.
// R23: Behaviour field codes one to ten; others none.
// R24: Outputs high only in their own on time.
module dead_time_pwm_cycle_engine #(
  parameter int CountWidth = pwm_engine_pkg::CountWidth
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic restart,
  input wire pwm_engine_pkg::scheme_type waveformSchemeSelect,
  input wire logic [1:0] synchronizerPrescale,
  input wire logic [1:0] counterPrescale,
  input wire pwm_engine_pkg::compare_set_type compares,
  input wire pwm_engine_pkg::input_control_type inputControlFirst,
  input wire pwm_engine_pkg::input_control_type inputControlSecond,
  input wire pwm_engine_pkg::delay_control_type delayControl,
  input wire logic eventFirst,
  input wire logic eventSecond,
  output logic pwmOutputFirst,
  output logic pwmOutputSecond,
  output pwm_engine_pkg::cycle_state_type cycleState,
  output logic [CountWidth-1:0] captureFirst,
  output logic [CountWidth-1:0] captureSecond,
  output logic blanking
);

  logic [7:0] divCnt;
  logic [2:0] cntExp;
  logic [7:0] cntMask;
  logic [7:0] dlyMask;
  logic cntTick;
  logic dlyTick;

  // Divide-by factors are powers of two, so one free-running counter serves both clocks.
  assign cntExp = {1'b0, synchronizerPrescale} + {1'b0, counterPrescale};
  assign cntMask = 8'(8'h01 << cntExp) - 8'h01;
  assign dlyMask = 8'(8'h01 << delayControl.delayClockDivider) - 8'h01;
  assign cntTick = enable && ((divCnt & cntMask) == cntMask); // [R01]
  assign dlyTick = (divCnt & dlyMask) == dlyMask; // [R18]

  always_ff @(posedge clk) begin
    if (sys_rst || !enable) begin
      divCnt <= pwm_engine_pkg::DividerReset;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // Input path: two-flop synchronizer, optional filter, qualification.
  pwm_engine_pkg::input_control_type ctl [2];
  logic [1:0] rawIn;
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic [1:0] filtered;
  logic [1:0] evt;
  logic [1:0] evtPrev;
  logic [1:0] rise;
  logic [1:0] asyncHit;
  logic [3:0] taps [2];

  assign ctl[0] = inputControlFirst;
  assign ctl[1] = inputControlSecond;
  assign rawIn = {eventSecond, eventFirst};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA <= 2'h0;
      syncB <= 2'h0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : gInput
    wire allHigh = &taps[i];
    wire allLow = ~|taps[i];
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        taps[i] <= pwm_engine_pkg::FilterReset;
        filtered[i] <= 1'b0;
      end else if (cntTick) begin
        taps[i] <= {taps[i][2:0], syncB[i]};
        if (allHigh || allLow) begin
          filtered[i] <= allHigh; // [R20]
        end
      end
    end
    wire level = ctl[i].filterEnable ? filtered[i] : syncB[i];
    wire blanked = (i == 0) && blanking; // [R15]
    assign evt[i] = ctl[i].triggerInputEnable && level && !blanked; // [R14]
    assign asyncHit[i] = ctl[i].triggerInputEnable && ctl[i].unsynchronizedDetectEnable
                         && syncB[i]; // [R21]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evtPrev <= 2'h0;
    end else begin
      evtPrev <= evt;
    end
  end

  assign rise = evt & ~evtPrev;

  // Counter and cycle sequencing.
  logic [CountWidth-1:0] cnt;
  logic [1:0] phase;
  logic countUp;
  logic firstCycle;
  logic running;
  logic rawFirst;
  logic rawSecond;
  logic [CountWidth-1:0] next_cnt;
  logic [1:0] next_phase;
  logic next_countUp;
  logic cycleEnd;
  logic [CountWidth-1:0] top;
  logic isDual;
  logic freeze;
  logic jumpToSecond;
  logic jumpToFirst;
  logic [CountWidth-1:0] setA;
  logic [CountWidth-1:0] clrA;
  logic [CountWidth-1:0] setB;
  logic [CountWidth-1:0] clrB;

  assign setA = compares.setFirst;
  assign clrA = compares.clearFirst;
  assign setB = compares.setSecond;
  assign clrB = compares.clearSecond;
  assign isDual = waveformSchemeSelect == pwm_engine_pkg::SCHEME_DUAL_SLOPE; // [R03]

  wire [CountWidth-1:0] fourTop = (phase == 2'd0) ? setA : (phase == 2'd1) ? clrA
                                : (phase == 2'd2) ? setB : clrB;
  assign top = (waveformSchemeSelect == pwm_engine_pkg::SCHEME_FOUR_RAMP) ? fourTop // [R08]
             : (waveformSchemeSelect == pwm_engine_pkg::SCHEME_TWO_RAMP && !phase[1]) ? clrA
             : clrB; // [R04] [R07]

  always_comb begin
    next_cnt = cnt + 1'b1;
    next_phase = phase;
    next_countUp = countUp;
    cycleEnd = 1'b0;
    case (waveformSchemeSelect)
      pwm_engine_pkg::SCHEME_ONE_RAMP: begin
        if (cnt == top) begin
          next_cnt = '0; // [R04]
          cycleEnd = 1'b1;
        end
      end
      pwm_engine_pkg::SCHEME_TWO_RAMP: begin
        if (cnt == top) begin
          next_cnt = '0; // [R07]
          next_phase = phase[1] ? 2'd0 : 2'd2;
          cycleEnd = phase[1];
        end
      end
      pwm_engine_pkg::SCHEME_FOUR_RAMP: begin
        if (cnt == top) begin
          next_cnt = '0; // [R08]
          next_phase = phase + 2'd1;
          cycleEnd = phase == 2'd3;
        end
      end
      default: begin
        // Each turning point is held one extra clock so the period is 2 x (top + 1).
        if (countUp) begin
          if (cnt == clrB) begin
            next_cnt = cnt; // [R09]
            next_countUp = 1'b0;
            cycleEnd = 1'b1;
          end
        end else if (cnt == '0) begin
          next_cnt = cnt;
          next_countUp = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    endcase
  end

  // Own-output compare levels; values past the cycle end never come up.
  logic onFirst;
  logic onSecond;
  logic halfSecond;
  wire clrAValid = clrA >= setA;
  wire oneOnA = (cnt >= setA) && (!clrAValid || (cnt < clrA)); // [R05]
  wire oneOnB = (cnt >= setB) && (cnt < clrB);

  always_comb begin
    case (waveformSchemeSelect)
      pwm_engine_pkg::SCHEME_ONE_RAMP: begin
        onFirst = oneOnA;
        onSecond = oneOnB;
        // The clear-second count already belongs to the next cycle's first dead time.
        halfSecond = (clrAValid ? (cnt >= clrA) : (cnt >= setB)) && (cnt < clrB); // [R02]
      end
      pwm_engine_pkg::SCHEME_TWO_RAMP: begin
        onFirst = !phase[1] && (cnt >= setA) && (cnt < clrA);
        onSecond = phase[1] && (cnt >= setB) && (cnt < clrB);
        halfSecond = phase[1] ? (cnt < clrB) : (cnt >= clrA); // [R02]
      end
      pwm_engine_pkg::SCHEME_FOUR_RAMP: begin
        onFirst = phase == 2'd1;
        onSecond = phase == 2'd3;
        halfSecond = phase[1];
      end
      default: begin
        onFirst = rawFirst && !firstCycle; // [R13]
        onSecond = rawSecond;
        halfSecond = !countUp;
      end
    endcase
  end

  pwm_engine_pkg::cycle_state_type next_state;
  assign next_state = onFirst ? pwm_engine_pkg::ON_TIME_FIRST
                    : onSecond ? pwm_engine_pkg::ON_TIME_SECOND
                    : halfSecond ? pwm_engine_pkg::DEAD_TIME_SECOND
                    : pwm_engine_pkg::DEAD_TIME_FIRST; // [R02]

  // Fault handling, one set of flags per input and one halt flag shared by both.
  logic [1:0] edgeStop;
  logic [1:0] jumped;
  logic halted;
  logic [1:0] ownHalf;
  logic [1:0] ownOn;
  logic [1:0] killOwn;
  logic [1:0] killAll;
  logic [1:0] waiting;
  logic [1:0] jumpReq;
  logic [1:0] haltReq;
  pwm_engine_pkg::fault_behaviour_type fb [2];

  assign ownHalf = {halfSecond, !halfSecond};
  assign ownOn = {onSecond, onFirst};

  for (genvar i = 0; i < 2; i++) begin : gFault
    // Reserved codes above ten fall back to no action.
    assign fb[i] = (ctl[i].faultBehaviourSelect > 4'hA) ? pwm_engine_pkg::FAULT_NONE
                 : pwm_engine_pkg::fault_behaviour_type'(ctl[i].faultBehaviourSelect); // [R23]
    wire ownGroup = fb[i] inside {pwm_engine_pkg::FAULT_JUMP_WAIT,
      pwm_engine_pkg::FAULT_EXEC_WAIT, pwm_engine_pkg::FAULT_EXEC_ACTIVE,
      pwm_engine_pkg::FAULT_LEVEL_STOP, pwm_engine_pkg::FAULT_EDGE_STOP,
      pwm_engine_pkg::FAULT_EDGE_JUMP};
    wire allGroup = (fb[i] != pwm_engine_pkg::FAULT_NONE) && !ownGroup;
    wire lvlOwn = fb[i] inside {pwm_engine_pkg::FAULT_JUMP_WAIT,
      pwm_engine_pkg::FAULT_EXEC_WAIT, pwm_engine_pkg::FAULT_EXEC_ACTIVE,
      pwm_engine_pkg::FAULT_LEVEL_STOP};
    assign killOwn[i] = (evt[i] && lvlOwn) || edgeStop[i]
                      || (asyncHit[i] && ownGroup); // [R16] [R21]
    assign killAll[i] = (evt[i] && allGroup) || (asyncHit[i] && allGroup); // [R15]
    assign jumpReq[i] = (rise[i] && ownHalf[i] && fb[i] == pwm_engine_pkg::FAULT_JUMP_WAIT)
                      || (rise[i] && ownOn[i] && fb[i] == pwm_engine_pkg::FAULT_EDGE_JUMP);
    assign waiting[i] = evt[i] && jumped[i];
    assign haltReq[i] = evt[i] && fb[i] == pwm_engine_pkg::FAULT_SOFTWARE;

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        edgeStop[i] <= 1'b0;
        jumped[i] <= 1'b0;
      end else begin
        // The latch set wins over its release in the same clock.
        edgeStop[i] <= (rise[i] && ownOn[i] && fb[i] == pwm_engine_pkg::FAULT_EDGE_STOP)
                     || (edgeStop[i] && ownOn[i]);
        jumped[i] <= (jumpReq[i] && fb[i] == pwm_engine_pkg::FAULT_JUMP_WAIT)
                   || (jumped[i] && evt[i]);
      end
    end
  end

  assign jumpToSecond = jumpReq[0] && !isDual;
  assign jumpToFirst = jumpReq[1] && !isDual;
  assign freeze = halted || (|waiting);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      halted <= 1'b0;
    end else begin
      // A restart while the event is still high is ignored; the engine stays halted.
      halted <= (|haltReq) || (halted && !restart);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !enable || (restart && !(|haltReq))) begin
      running <= enable && !sys_rst;
      cnt <= isDual ? clrB : pwm_engine_pkg::CountReset; // [R13]
      phase <= 2'd0;
      countUp <= 1'b0;
      firstCycle <= 1'b1;
    end else if (!running) begin
      running <= 1'b1;
    end else if (jumpToSecond) begin
      cnt <= (waveformSchemeSelect == pwm_engine_pkg::SCHEME_ONE_RAMP) ? clrA : '0;
      phase <= 2'd2;
    end else if (jumpToFirst) begin
      cnt <= pwm_engine_pkg::CountReset;
      phase <= 2'd0;
    end else if (cntTick && !freeze) begin
      cnt <= next_cnt;
      phase <= next_phase;
      countUp <= next_countUp;
      if (cycleEnd) begin
        firstCycle <= 1'b0;
      end
    end
  end

  // Dual slope raw levels; clear-first is never looked at here.
  wire dualStep = isDual && cntTick && !freeze && running;
  always_ff @(posedge clk) begin
    if (sys_rst || !enable) begin
      rawFirst <= 1'b0;
      rawSecond <= 1'b0;
    end else if (dualStep) begin
      if (cnt == setA) begin
        rawFirst <= countUp; // [R10] [R12]
      end
      if (cnt == setB) begin
        rawSecond <= !countUp; // [R11]
      end
    end
  end

  // Blanking of the first input, started at the selected state entry.
  logic [7:0] dlyCnt;
  logic [1:0] stateNow;
  wire blankOn = delayControl.delayFunctionSelect == pwm_engine_pkg::DelayBlanking; // [R17]
  wire blankStart = blankOn && (next_state != cycleState)
                  && (next_state == 2'(delayControl.delayTriggerSource + 2'd1)); // [R17]
  assign stateNow = cycleState;

  always_ff @(posedge clk) begin
    if (sys_rst || !blankOn || !enable) begin
      blanking <= 1'b0;
      dlyCnt <= 8'h00;
    end else if (blankStart) begin
      blanking <= delayControl.delayCountValue != 8'h00;
      dlyCnt <= 8'h00;
    end else if (blanking && dlyTick) begin
      dlyCnt <= dlyCnt + 8'h01;
      if (dlyCnt + 8'h01 == delayControl.delayCountValue) begin
        blanking <= 1'b0; // [R18]
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (sys_rst || !enable) begin
      pwmOutputFirst <= 1'b0;
      pwmOutputSecond <= 1'b0;
      cycleState <= pwm_engine_pkg::DEAD_TIME_FIRST;
    end else begin
      pwmOutputFirst <= onFirst && !killOwn[0] && !(|killAll) && !halted; // [R24]
      pwmOutputSecond <= onSecond && !killOwn[1] && !(|killAll) && !halted; // [R24]
      cycleState <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      captureFirst <= '0;
      captureSecond <= '0;
    end else begin
      if (rise[0] && ctl[0].captureAction) begin
        captureFirst <= cnt; // [R14]
      end
      if (rise[1] && ctl[1].captureAction) begin
        captureSecond <= cnt; // [R14]
      end
    end
  end

endmodule : dead_time_pwm_cycle_engine

/* pwm_engine_props.sv */
module pwm_engine_props #(
  parameter int CountWidth = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic restart,
  input wire pwm_engine_pkg::scheme_type waveformSchemeSelect,
  input wire logic [1:0] synchronizerPrescale,
  input wire logic [1:0] counterPrescale,
  input wire pwm_engine_pkg::compare_set_type compares,
  input wire pwm_engine_pkg::input_control_type inputControlFirst,
  input wire pwm_engine_pkg::input_control_type inputControlSecond,
  input wire pwm_engine_pkg::delay_control_type delayControl,
  input wire logic eventFirst,
  input wire logic eventSecond,
  input wire logic pwmOutputFirst,
  input wire logic pwmOutputSecond,
  input wire pwm_engine_pkg::cycle_state_type cycleState,
  input wire logic [CountWidth-1:0] captureFirst,
  input wire logic [CountWidth-1:0] captureSecond,
  input wire logic blanking
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic killFirst = inputControlFirst.triggerInputEnable && !inputControlFirst.filterEnable
      && inputControlFirst.faultBehaviourSelect == 4'h4 && !blanking && eventFirst;
  // Fault inputs change the flow, so state order is only judged while both are off.
  wire logic plainRun = enable && !restart && !inputControlFirst.triggerInputEnable
      && !inputControlSecond.triggerInputEnable
      && waveformSchemeSelect != pwm_engine_pkg::SCHEME_DUAL_SLOPE
      && compares.setFirst < compares.clearFirst && compares.clearFirst <= compares.setSecond
      && compares.setSecond < compares.clearSecond;

  a_reset_clears_outs: assert property (disable iff (1'b0) sys_rst |=> !pwmOutputFirst
      && !pwmOutputSecond && captureFirst == '0 && cycleState == pwm_engine_pkg::DEAD_TIME_FIRST)
    else $error("outputs not cleared by reset");
  a_disable_quiets: assert property ((!enable)[*2] |=> !pwmOutputFirst && !pwmOutputSecond)
    else $error("output high while disabled");
  a_stop_all_kill: assert property (killFirst[*4] |-> !pwmOutputFirst && !pwmOutputSecond)
    else $error("fault did not stop outputs in time");
  a_ramp_no_overlap: assert property (enable && $past(enable) && $stable(waveformSchemeSelect)
      && (waveformSchemeSelect == pwm_engine_pkg::SCHEME_TWO_RAMP
      || waveformSchemeSelect == pwm_engine_pkg::SCHEME_FOUR_RAMP)
      |-> !(pwmOutputFirst && pwmOutputSecond))
    else $error("outputs overlap in multi ramp scheme");
  a_state_in_order: assert property (plainRun && $past(plainRun)
      && cycleState != $past(cycleState) |-> cycleState == 2'($past(cycleState) + 2'h1))
    else $error("cycle state skipped");
  a_capture_gate_one: assert property ((!inputControlFirst.captureAction)[*3]
      |=> $stable(captureFirst))
    else $error("first capture moved without action");
  a_capture_gate_two: assert property ((!inputControlSecond.captureAction)[*3]
      |=> $stable(captureSecond))
    else $error("second capture moved without action");
  a_dual_first_quiet: assert property ($rose(enable)
      && waveformSchemeSelect == pwm_engine_pkg::SCHEME_DUAL_SLOPE
      && compares.clearSecond >= 12'h0003 |-> (!pwmOutputFirst)[*8])
    else $error("first output high in first dual slope cycle");

  cover property (killFirst[*4]);
  cover property (pwmOutputFirst && pwmOutputSecond);
  cover property (plainRun && cycleState == pwm_engine_pkg::ON_TIME_SECOND);
endmodule : pwm_engine_props

/* fault_event_source.sv */
module fault_event_source (
  input wire logic clk,
  input wire logic raiseFirst,
  input wire logic raiseSecond,
  output logic eventFirst,
  output logic eventSecond
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    eventFirst = 1'b0;
    eventSecond = 1'b0;
  end
  // Events arrive as clean levels, moved off the sampling edge to avoid races.
  always @(posedge clk) begin
    eventFirst <= #1 raiseFirst;
    eventSecond <= #1 raiseSecond;
  end
endmodule : fault_event_source

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable = 1'b0;
  logic restart = 1'b0;
  pwm_engine_pkg::scheme_type scheme = pwm_engine_pkg::SCHEME_ONE_RAMP;
  logic [1:0] prescale = 2'h0;
  pwm_engine_pkg::compare_set_type compares = '0;
  pwm_engine_pkg::input_control_type ctlFirst = '0;
  pwm_engine_pkg::input_control_type ctlSecond = '0;
  pwm_engine_pkg::delay_control_type delayControl = '0;
  logic raiseFirst = 1'b0;
  logic raiseSecond = 1'b0;
  logic eventFirst, eventSecond, pwmOutputFirst, pwmOutputSecond, blanking;
  pwm_engine_pkg::cycle_state_type cycleState;
  logic [11:0] captureFirst, captureSecond;
  int miscompares = 0;
  int checked = 0;

  initial begin
    forever #2.5 clk = ~clk;
  end

  fault_event_source fault_event_source_i (.clk(clk), .raiseFirst(raiseFirst),
    .raiseSecond(raiseSecond), .eventFirst(eventFirst), .eventSecond(eventSecond));

  dead_time_pwm_cycle_engine #(.CountWidth(12)) dead_time_pwm_cycle_engine_i (.clk(clk),
    .sys_rst(sys_rst), .enable(enable), .restart(restart), .waveformSchemeSelect(scheme),
    .synchronizerPrescale(prescale), .counterPrescale(prescale), .compares(compares),
    .inputControlFirst(ctlFirst), .inputControlSecond(ctlSecond), .delayControl(delayControl),
    .eventFirst(eventFirst), .eventSecond(eventSecond), .pwmOutputFirst(pwmOutputFirst),
    .pwmOutputSecond(pwmOutputSecond), .cycleState(cycleState), .captureFirst(captureFirst),
    .captureSecond(captureSecond), .blanking(blanking));

  task automatic close_out();
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(logic [31:0] seen, logic [31:0] expected);
    checked++;
    if (seen !== expected) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic measure(input int span, output logic [31:0] hi1, output logic [31:0] hi2,
      output logic [31:0] up1, output logic [31:0] up2);
    logic p1;
    logic p2;
    {hi1, hi2, up1, up2} = '0;
    p1 = pwmOutputFirst;
    p2 = pwmOutputSecond;
    repeat (span) begin
      @(negedge clk);
      hi1 += 32'(pwmOutputFirst);
      hi2 += 32'(pwmOutputSecond);
      up1 += 32'(pwmOutputFirst & ~p1);
      up2 += 32'(pwmOutputSecond & ~p2);
      p1 = pwmOutputFirst;
      p2 = pwmOutputSecond;
    end
  endtask : measure

  // Scheme, prescale, compares and input controls are only touched with the engine stopped.
  task automatic start(pwm_engine_pkg::scheme_type s, logic [1:0] pre, logic [47:0] cmp,
      pwm_engine_pkg::input_control_type c1, pwm_engine_pkg::input_control_type c2);
    enable = 1'b0;
    repeat (2) @(negedge clk);
    scheme = s;
    prescale = pre;
    compares = cmp;
    ctlFirst = c1;
    ctlSecond = c2;
    @(negedge clk);
    enable = 1'b1;
  endtask : start

  task automatic ramp_case(pwm_engine_pkg::scheme_type s, logic [1:0] pre, logic [47:0] cmp,
      int period, logic [31:0] e2, logic [31:0] h1);
    logic [31:0] hi1, hi2, up1, up2;
    start(s, pre, cmp, '0, '0);
    repeat (3 * period) @(negedge clk);
    measure(4 * period, hi1, hi2, up1, up2);
    check(up1, 32'h0000_0004);
    check(up2, e2);
    if (h1 != 0) check(hi1, h1);
  endtask : ramp_case

  task automatic fault_case(pwm_engine_pkg::input_control_type c, logic onSecond,
      logic [31:0] e1, logic [31:0] e2);
    logic [31:0] hi1, hi2, up1, up2;
    start(pwm_engine_pkg::SCHEME_ONE_RAMP, 2'h0, 48'h0010_0300_5007,
      onSecond ? '0 : c, onSecond ? c : '0);
    repeat (24) @(negedge clk);
    raiseFirst = !onSecond;
    raiseSecond = onSecond;
    repeat (6) @(negedge clk);
    measure(32, hi1, hi2, up1, up2);
    check(hi1, e1);
    check(hi2, e2);
    raiseFirst = 1'b0;
    raiseSecond = 1'b0;
    repeat (8) @(negedge clk);
  endtask : fault_case

  task automatic test_ramps();
    ramp_case(pwm_engine_pkg::SCHEME_ONE_RAMP, 2'h0, 48'h0010_0300_5007, 8, 4, 8);
    ramp_case(pwm_engine_pkg::SCHEME_ONE_RAMP, 2'h1, 48'h0010_0300_5007, 32, 4, 32);
    ramp_case(pwm_engine_pkg::SCHEME_ONE_RAMP, 2'h0, 48'h0010_0300_9007, 8, 0, 8);
    ramp_case(pwm_engine_pkg::SCHEME_TWO_RAMP, 2'h0, 48'h0010_0300_2005, 10, 4, 0);
    ramp_case(pwm_engine_pkg::SCHEME_FOUR_RAMP, 2'h0, 48'h0010_0200_3004, 14, 4, 0);
  endtask : test_ramps

  task automatic test_dual_slope();
    ramp_case(pwm_engine_pkg::SCHEME_DUAL_SLOPE, 2'h0, 48'h0020_0900_1005, 12, 4, 0);
    ramp_case(pwm_engine_pkg::SCHEME_DUAL_SLOPE, 2'h0, 48'h0020_0000_1005, 12, 4, 0);
  endtask : test_dual_slope

  task automatic test_capture_blank();
    logic [31:0] n;
    n = '0;
    start(pwm_engine_pkg::SCHEME_ONE_RAMP, 2'h0, 48'h0010_0300_5007,
      '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0}, '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0});
    repeat (24) @(negedge clk);
    raiseFirst = 1'b1;
    raiseSecond = 1'b1;
    repeat (8) @(negedge clk);
    check(32'(captureFirst), 32'h0000_0002);
    check(32'(captureSecond), 32'h0000_0002);
    raiseFirst = 1'b0;
    raiseSecond = 1'b0;
    repeat (8) @(negedge clk);
    // Blanking only, the delayed output event stays unused.
    delayControl = '{2'h1, 2'h0, 2'h0, 8'h02};
    repeat (8) @(negedge clk);
    repeat (32) begin
      @(negedge clk);
      n += 32'(blanking);
    end
    check(n, 32'h0000_0008);
    delayControl = '0;
    repeat (4) @(negedge clk);
  endtask : test_capture_blank

  task automatic test_faults();
    fault_case('{1'b1, 1'b0, 1'b0, 1'b0, 4'h4}, 1'b0, 0, 0);
    fault_case('{1'b1, 1'b0, 1'b0, 1'b0, 4'h4}, 1'b1, 0, 0);
    fault_case('{1'b0, 1'b0, 1'b0, 1'b0, 4'h4}, 1'b0, 8, 8);
    fault_case('{1'b1, 1'b0, 1'b0, 1'b0, 4'h0}, 1'b0, 8, 8);
    fault_case('{1'b1, 1'b0, 1'b0, 1'b0, 4'hB}, 1'b0, 8, 8);
    fault_case('{1'b1, 1'b0, 1'b0, 1'b0, 4'hA}, 1'b0, 0, 8);
  endtask : test_faults

  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    test_ramps();
    test_dual_slope();
    test_capture_blank();
    test_faults();
    close_out();
  end

  // The whole sequence needs some 1230 clocks; over twenty times that means a hang.
  initial begin
    #150us;
    miscompares++;
    close_out();
  end
endmodule : tb_top

bind dead_time_pwm_cycle_engine pwm_engine_props #(.CountWidth(CountWidth)) pwm_engine_props_i (
  .clk(clk), .sys_rst(sys_rst), .enable(enable), .restart(restart),
  .waveformSchemeSelect(waveformSchemeSelect), .synchronizerPrescale(synchronizerPrescale),
  .counterPrescale(counterPrescale), .compares(compares), .inputControlFirst(inputControlFirst),
  .inputControlSecond(inputControlSecond), .delayControl(delayControl), .eventFirst(eventFirst),
  .eventSecond(eventSecond), .pwmOutputFirst(pwmOutputFirst), .pwmOutputSecond(pwmOutputSecond),
  .cycleState(cycleState), .captureFirst(captureFirst), .captureSecond(captureSecond),
  .blanking(blanking));
